// ==== src/spi_dg_pkg.sv ====
/*
  shared constants for the 40-bit datagram link: widths, field positions,
  status byte layout and the host's register offsets.
  assumes one system clock for both ends and a link clock well below it.
*/
package spi_dg_pkg;
  // ==========================================================
  // datagram layout
  localparam int FRAME_BITS   = 40;
  localparam int DATA_BITS    = 32;
  localparam int ADDR_BITS    = 7;
  localparam int WRITE_BIT    = 39;
  localparam int STAT_MSB     = 39;
  localparam int STAT_LSB     = 32;
  localparam int CNT_W        = 6;
  // ==========================================================
  // status byte fields
  localparam int ST_RESERVED  = 7;
  localparam int ST_STOP2     = 6;
  localparam int ST_STOP1     = 5;
  localparam int ST_SPEED2    = 4;
  localparam int ST_SPEED1    = 3;
  localparam int ST_FAULT2    = 2;
  localparam int ST_FAULT1    = 1;
  localparam int ST_RESET     = 0;
  localparam int GS_RESET     = 0;
  localparam int GS_FAULT1    = 1;
  localparam int GS_FAULT2    = 2;
  localparam int RS_STOP_L    = 0;
  localparam int RS_SPEED_HIT = 8;
  // ==========================================================
  // device register index of the global status flags
  localparam logic [6:0]  GLOBAL_STATUS_FLAGS_ADDR = 7'h01;
  localparam logic [39:0] FRAME_ZERO = 40'h00_0000_0000;
  // ==========================================================
  // host apb register offsets (bytes)
  localparam logic [7:0] REG_TX_LO  = 8'h00; // data bits 31:0
  localparam logic [7:0] REG_TX_HI  = 8'h04; // bits 7:0 = addr byte
  localparam logic [7:0] REG_CTRL   = 8'h08; // 15:0 half period, 16 go
  localparam logic [7:0] REG_STAT   = 8'h0c; // 0 busy
  localparam logic [7:0] REG_RX_LO  = 8'h10;
  localparam logic [7:0] REG_RX_HI  = 8'h14; // bits 7:0 = status byte
  localparam int CTRL_GO            = 16;
  localparam logic [15:0] HALF_RST  = 16'h0004;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LEAD = 2'b01,
    H_SHIFT = 2'b10,
    H_TAIL = 2'b11
  } host_state_t;
endpackage

// ==== src/spi_dg_if.sv ====
/*
  link wires between the host end and the device end.
  assumes the bench drives clk and reset_n to both ends.
*/
interface spi_dg_if;
  logic sck;
  logic mosi;
  logic miso;
  logic chipSelectN;
  modport host (output sck, output mosi, output chipSelectN, input miso);
  modport device (input sck, input mosi, input chipSelectN, output miso);
endinterface

// ==== src/spi_dg_device.sv ====
/*
  device end: synchronises the link, shifts 40-bit datagrams, executes
  them on the rising select edge and offers a simple register port.
  assumes the link clock runs at most at a quarter of clk.
*/
module spi_dg_device
  import spi_dg_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // link
  spi_dg_if.device          link,
  // register port
  output logic              regWrite,
  output logic              regRead,
  output logic [6:0]        regAddr,
  output logic [31:0]       regWdata,
  input  wire logic [31:0]  regRdata,
  // motion and global status
  input  wire logic [31:0]  axis1_motion_status,
  input  wire logic [31:0]  axis2_motion_status,
  input  wire logic [2:0]   global_status_flags
);
  import spi_dg_pkg::*;

  // ==========================================================
  // synchronisers
  logic [1:0] sckSync_r, mosiSync_r, csSync_r;
  logic       sckPrev_r, csPrev_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sckSync_r  <= 2'h0;
      mosiSync_r <= 2'h0;
      csSync_r   <= 2'h3;
      sckPrev_r  <= 1'b0;
      csPrev_r   <= 1'b1;
    end else begin
      sckSync_r  <= {sckSync_r[0], link.sck};
      mosiSync_r <= {mosiSync_r[0], link.mosi};
      csSync_r   <= {csSync_r[0], link.chipSelectN};
      sckPrev_r  <= sckSync_r[1];
      csPrev_r   <= csSync_r[1];
    end
  end
  logic sckRise, sckFall, csFall, csRise, selected;
  assign selected = !csSync_r[1];
  assign sckRise  = selected && sckSync_r[1] && !sckPrev_r;
  assign sckFall  = selected && !sckSync_r[1] && sckPrev_r;
  assign csFall   = csPrev_r && !csSync_r[1];
  assign csRise   = !csPrev_r && csSync_r[1];

  // ==========================================================
  // status byte
  logic [7:0] statusByte;
  always_comb begin
    statusByte              = 8'h00;
    statusByte[ST_STOP2]    = axis2_motion_status[RS_STOP_L];
    statusByte[ST_STOP1]    = axis1_motion_status[RS_STOP_L];
    statusByte[ST_SPEED2]   = axis2_motion_status[RS_SPEED_HIT];
    statusByte[ST_SPEED1]   = axis1_motion_status[RS_SPEED_HIT];
    statusByte[ST_FAULT2]   = global_status_flags[GS_FAULT2];
    statusByte[ST_FAULT1]   = global_status_flags[GS_FAULT1];
    statusByte[ST_RESET]    = global_status_flags[GS_RESET];
  end

  // ==========================================================
  // shift register
  // one register serves in and out, so bits past the 40th pass
  // through it and leave 40 clocks later for daisy chains
  logic [39:0] shift_r;
  logic        misoBit_r;
  logic [31:0] pending_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift_r   <= FRAME_ZERO;
      misoBit_r <= 1'b0;
    end else if (csFall) begin
      shift_r   <= {statusByte, pending_r};
      misoBit_r <= statusByte[7];
    end else if (sckRise) begin
      shift_r   <= {shift_r[38:0], mosiSync_r[1]};
    end else if (sckFall) begin
      misoBit_r <= shift_r[39];
    end
  end
  assign link.miso = misoBit_r;

  // ==========================================================
  // command execution on select rise
  logic        rdPending_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regWrite    <= 1'b0;
      regRead     <= 1'b0;
      regAddr     <= 7'h00;
      regWdata    <= 32'h0000_0000;
      rdPending_r <= 1'b0;
    end else begin
      regWrite    <= 1'b0;
      regRead     <= 1'b0;
      rdPending_r <= regRead;
      if (csRise) begin
        regAddr  <= shift_r[38:32];
        regWdata <= shift_r[31:0];
        regWrite <= shift_r[WRITE_BIT];
        regRead  <= !shift_r[WRITE_BIT];
      end
    end
  end

  // register value one cycle after the read strobe; the next select
  // cannot fall sooner, the sync chain alone spans three cycles
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pending_r <= 32'h0000_0000;
    end else if (regWrite) begin
      pending_r <= regWdata;
    end else if (rdPending_r) begin
      pending_r <= regRdata;
    end
  end
endmodule

// ==== src/spi_dg_host.sv ====
/*
  host end: an apb slave takes a 40-bit datagram, shifts it out msb first
  on a divided link clock, and stores the 40-bit answer.
  assumes the bench joins the link interface to the device end.
*/
module spi_dg_host
  import spi_dg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  spi_dg_if.host           link
);
  import spi_dg_pkg::*;

  // ==========================================================
  // registers
  host_state_t state_r;
  logic [31:0] txLo_r, rxLo_r;
  logic [7:0]  txHi_r, rxHi_r;
  logic [15:0] half_r, divCnt_r;
  logic [5:0]  bitCnt_r;
  logic [39:0] sh_r;
  // answer bits are taken at the end of each high phase: the far end
  // needs about five clk to turn a falling edge into a settled bit
  // here, more than the four clk of the shortest half period
  logic [39:0] rxSh_r;
  logic        sck_r, cs_r, mosi_r, go;
  logic [1:0]  misoSync_r;
  logic        access;
  assign access = psel && penable;
  assign go = access && pwrite && paddr == REG_CTRL
              && pwdata[CTRL_GO] && state_r == H_IDLE;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txLo_r  <= 32'h0000_0000;
      txHi_r  <= 8'h00;
      half_r  <= HALF_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !pready;
      pslverr <= 1'b0;
      if (psel && !pready) begin
        pslverr <= paddr > REG_RX_HI || paddr[1:0] != 2'h0;
        unique case (paddr)
          REG_TX_LO: prdata <= txLo_r;
          REG_TX_HI: prdata <= {24'h000000, txHi_r};
          REG_CTRL:  prdata <= {16'h0000, half_r};
          REG_STAT:  prdata <= {31'h00000000, state_r != H_IDLE};
          REG_RX_LO: prdata <= rxLo_r;
          REG_RX_HI: prdata <= {24'h000000, rxHi_r};
          default:   prdata <= 32'h0000_0000;
        endcase
      end
      if (access && pready && pwrite) begin
        if (paddr == REG_TX_LO) txLo_r <= pwdata;
        if (paddr == REG_TX_HI) txHi_r <= pwdata[7:0];
        if (paddr == REG_CTRL && state_r == H_IDLE) begin
          half_r <= (pwdata[15:0] < 16'h0004) ? 16'h0004 : pwdata[15:0];
        end
      end
    end
  end

  // ==========================================================
  // link sequencer
  logic tick;
  assign tick = divCnt_r == 16'h0000;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      misoSync_r <= 2'h0;
    end else begin
      misoSync_r <= {misoSync_r[0], link.miso};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r  <= H_IDLE;
      divCnt_r <= 16'h0000;
      bitCnt_r <= 6'h00;
      sh_r     <= FRAME_ZERO;
      rxSh_r   <= FRAME_ZERO;
      sck_r    <= 1'b0;
      cs_r     <= 1'b1;
      mosi_r   <= 1'b0;
      rxLo_r   <= 32'h0000_0000;
      rxHi_r   <= 8'h00;
    end else begin
      divCnt_r <= tick ? half_r - 16'h0001 : divCnt_r - 16'h0001;
      unique case (state_r)
        H_IDLE: if (go && pready) begin
          sh_r     <= {txHi_r, txLo_r};
          cs_r     <= 1'b0;
          mosi_r   <= txHi_r[7];
          divCnt_r <= half_r;
          bitCnt_r <= 6'h00;
          state_r  <= H_LEAD;
        end
        H_LEAD: if (tick) state_r <= H_SHIFT;
        H_SHIFT: if (tick) begin
          sck_r <= !sck_r;
          if (!sck_r) begin
            sh_r <= {sh_r[38:0], 1'b0};
            bitCnt_r <= bitCnt_r + 6'h01;
          end else begin
            rxSh_r <= {rxSh_r[38:0], misoSync_r[1]};
            if (bitCnt_r == 6'(FRAME_BITS)) begin
              state_r <= H_TAIL;
            end else begin
              mosi_r <= sh_r[39];
            end
          end
        end
        H_TAIL: if (tick) begin
          cs_r   <= 1'b1;
          rxHi_r <= rxSh_r[39:32];
          rxLo_r <= rxSh_r[31:0];
          state_r <= H_IDLE;
        end
      endcase
    end
  end
  assign link.sck         = sck_r;
  assign link.mosi        = mosi_r;
  assign link.chipSelectN = cs_r;
endmodule

// ==== sim/spi_dg_sva.sv ====
/*
  link checker: watches the wires that join host and device.
  assumes one clk for both ends and a synchronous reset_n.
*/
module spi_dg_sva (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // link
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic chipSelectN
);
  int   bits;
  logic sckQ;
  // ==========================================================
  // rising link clock edges in the current frame
  always_ff @(posedge clk) begin
    sckQ <= sck;
    if (!reset_n || chipSelectN)
      bits <= 0;
    else if (sck && !sckQ)
      bits <= bits + 1;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence frameStart;
    $fell(chipSelectN);
  endsequence
  sequence frameEnd;
    $rose(chipSelectN);
  endsequence
  bit_count_a: assert property (frameEnd |-> bits == 40)
    else $error("frame did not carry 40 clocks");
  select_held_a: assert property (
    !chipSelectN && bits < 40 |=> !chipSelectN)
    else $error("select rose inside a datagram");
  start_low_a: assert property (frameStart |-> !sck)
    else $error("link clock high at select fall");
  idle_clock_a: assert property (
    chipSelectN && $past(chipSelectN) |-> !sck)
    else $error("link clock moved while deselected");
  miso_fall_a: assert property (
    !chipSelectN && $changed(miso) |-> !sck)
    else $error("miso changed while link clock high");
  mosi_rise_a: assert property ($rose(sck) |-> $stable(mosi))
    else $error("mosi changed at link clock rise");
  high_phase_a: assert property ($rose(sck) |=> sck [*3])
    else $error("link clock high phase too short");
  low_phase_a: assert property (
    $fell(sck) && !chipSelectN |=> !sck [*3])
    else $error("link clock low phase too short");
endmodule

// ==== sim/spi_datagram_slave_tb_top.sv ====
/*
  bench: host and device joined by the link interface, apb tasks drive
  the host, a small register model answers the device.
  assumes the design files are compiled first.
*/
module spi_datagram_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_dg_pkg::*;
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] regRdata  = 32'h0;
  logic [31:0] ax1       = 32'h0;
  logic [31:0] ax2       = 32'h0;
  logic [2:0]  gsf       = 3'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        regWrite;
  logic        regRead;
  logic [6:0]  regAddr;
  logic [31:0] regWdata;
  logic [31:0] regs [128];
  logic [39:0] mon;
  logic [39:0] monMiso;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          cycles    = 0;
  spi_dg_if link ();
  spi_dg_host spi_dg_host_i (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  spi_dg_device spi_dg_device_i (.clk(clk), .reset_n(reset_n),
    .link(link), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .axis1_motion_status(ax1), .axis2_motion_status(ax2),
    .global_status_flags(gsf));
  spi_dg_sva spi_dg_sva_i (.clk(clk), .reset_n(reset_n), .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso), .chipSelectN(link.chipSelectN));
  always #2 clk = ~clk;
  // ==========================================================
  // register model; read data lands one cycle after the strobe
  always @(posedge clk) begin
    if (regWrite)
      regs[regAddr] <= regWdata;
    if (regRead) begin
      regRdata <= (regAddr == GLOBAL_STATUS_FLAGS_ADDR) ? {29'h0, gsf} : regs[regAddr];
      if (regAddr == GLOBAL_STATUS_FLAGS_ADDR)
        gsf <= 3'h0;
    end
  end
  // ==========================================================
  // wire monitor, sampled on the link clock rise, where the device samples mosi
  always @(posedge link.sck) begin
    if (!link.chipSelectN) begin
      mon     <= {mon[38:0], link.mosi};
      monMiso <= {monMiso[38:0], link.miso};
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [39:0] tx, output logic [39:0] rx);
    logic [31:0] q;
    logic        e;
    apb(1'b1, REG_TX_HI, {24'h0, tx[39:32]}, q, e);
    apb(1'b1, REG_TX_LO, tx[31:0], q, e);
    apb(1'b1, REG_CTRL, {15'h0, 1'b1, HALF_RST}, q, e);
    q = 32'h1;
    while (q[0] !== 1'b0)
      apb(1'b0, REG_STAT, 32'h0, q, e);
    apb(1'b0, REG_RX_LO, 32'h0, q, e);
    rx[31:0] = q;
    apb(1'b0, REG_RX_HI, 32'h0, q, e);
    rx[39:32] = q[7:0];
    chk(mon, tx);
    chk(monMiso, rx);
  endtask
  task automatic conclude();
    $display("errors %0d tests %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // hang guard, well above the ~4540 cycles of the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  // ==========================================================
  // tests
  initial begin
    logic [39:0] rx;
    logic [31:0] q;
    logic        e;
    logic [7:0]  s;
    foreach (regs[i]) regs[i] = 32'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    frame(40'ha2_00ab_cdef, rx);
    frame(40'ha2_0012_3456, rx);
    chk({8'h0, rx[31:0]}, 40'h00_00ab_cdef);
    chk({32'h0, rx[39:32]}, 40'h0);
    frame(40'h22_ffff_ffff, rx);
    chk(rx, 40'h00_0012_3456);
    frame(40'h22_0000_0000, rx);
    chk(rx, 40'h00_0012_3456);
    chk({8'h0, regs[7'h22]}, 40'h00_0012_3456);
    // one status source at a time; bit 7 must stay clear
    for (int i = 0; i < 7; i++) begin
      s = 8'h01 << i;
      @(posedge clk);
      gsf <= s[2:0];
      ax1 <= {23'h0, s[3], 7'h0, s[5]};
      ax2 <= {23'h0, s[4], 7'h0, s[6]};
      frame({8'h85, 24'h0, s}, rx);
      chk({32'h0, rx[39:32]}, {32'h0, s});
    end
    @(posedge clk);
    gsf <= 3'h5;
    ax2 <= 32'h0;
    frame({1'b0, GLOBAL_STATUS_FLAGS_ADDR, 32'h0}, rx);
    chk({32'h0, rx[39:32]}, 40'h05);
    frame(40'h00_0000_0000, rx);
    chk(rx, 40'h00_0000_0005);
    apb(1'b0, 8'h18, 32'h0, q, e);
    chk({39'h0, e}, 40'h1);
    conclude();
  end
endmodule
